// ---- rtl/fifo_flags_pkg.sv ----
/*
  fifo_flags_pkg: shared constants for the port control and flag block
  of the 64 x 36 two-port queue.
  assumes: imported whole by the design module; no clock of its own.
*/
package fifo_flags_pkg;

  // ----------------------------------------------------------------
  // storage shape
  // ----------------------------------------------------------------
  localparam int unsigned DATA_WIDTH  = 36;  // one long word
  localparam int unsigned DEPTH       = 64;  // long words stored
  localparam int unsigned PTR_WIDTH   = 7;   // address plus wrap bit
  localparam int unsigned BYTE_BITS   = 9;   // byte lane incl. parity
  localparam int unsigned WORD_BITS   = 18;  // word lane

  // ----------------------------------------------------------------
  // offset register values, picked by the two threshold inputs
  // ----------------------------------------------------------------
  localparam logic [4:0] OFFSET_HH = 5'h10;  // 16
  localparam logic [4:0] OFFSET_HL = 5'h0C;  // 12
  localparam logic [4:0] OFFSET_LH = 5'h08;  // 8
  localparam logic [4:0] OFFSET_LL = 5'h04;  // 4

  // ----------------------------------------------------------------
  // port b width codes {hi, lo}; both high selects the mailboxes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WIDTH_LONG = 2'b00,                      // 36-bit transfers
    WIDTH_BYTE = 2'b01,                      // 9-bit transfers
    WIDTH_WORD = 2'b10,                      // 18-bit transfers
    WIDTH_MAIL = 2'b11                       // mailbox access
  } width_sel_t;

  // reset value of the read pointer copy seen by the write side:
  // wrap bit flipped, so the queue looks full until it settles
  localparam logic [6:0] RD_SYNC_RESET = 7'h40;

endpackage

// ---- rtl/fifo_port_flags.sv ----
/*
  fifo_port_flags: port enable decode, 64 x 36 storage, two mailboxes
  and two-stage synchronised empty, almost-empty, full and almost-full
  flags of a two-port queue, port a writing and port b reading.
  assumes: both ports sampled on sys_clk_in, inputs synchronous to it;
  reset_in held for at least four edges; the testbench resolves the
  data buses from the output enables.
*/
`timescale 1ns/100ps

// Function
// - reset release loads offset from threshold picks
// - fifo read needs select, read, strobe, not empty
// - each fifo flag passes two flops on its port clock
// - empty flag low ignores fifo reads
// - empty drops after last byte or word
// - pointers advance per long word moved
// - written word readable after two edges
// - first sync edge needs skew after write
// - full flag low ignores fifo writes
// - full flag rises second edge after read
// - first sync edge needs skew after read
// - almost-empty high above offset words stored
// - almost-empty rises second edge after write
// - flag levels follow fill table exactly
// - port a reads mailbox two, frees it
// - port a writes fifo or mailbox one
// - port b drives fifo register or mailbox one
// - port b reads mailbox one, frees it
// - port b writes mailbox two
// - full mailbox ignores writes until read
// - reset clears pointers and sets flag levels
module fifo_port_flags
  import fifo_flags_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_WIDTH,  // long word bits
  parameter int unsigned WORDS = DEPTH         // storage depth
)
(
  // clock, reset, enable
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  input  wire logic             clk_en_in,
  // offset picks, taken at reset release
  input  wire logic             fill_threshold_pick_lo_in,
  input  wire logic             fill_threshold_pick_hi_in,
  // port a control
  input  wire logic             port_a_select_n_in,
  input  wire logic             port_a_dir_select_in,
  input  wire logic             port_a_strobe_on_in,
  input  wire logic             port_a_mailbox_pick_in,
  // port a data pin
  input  wire logic [WIDTH-1:0] port_a_data_in,
  output logic      [WIDTH-1:0] port_a_data_out,
  output logic                  port_a_data_oe_out,
  // port b control
  input  wire logic             port_b_select_n_in,
  input  wire logic             port_b_dir_select_in,
  input  wire logic             port_b_strobe_on_in,
  input  wire logic             port_b_width_sel_lo_in,
  input  wire logic             port_b_width_sel_hi_in,
  // port b data pin
  input  wire logic [WIDTH-1:0] port_b_data_in,
  output logic      [WIDTH-1:0] port_b_data_out,
  output logic                  port_b_data_oe_out,
  // flags, all active low
  output logic                  write_side_full_n_out,
  output logic                  almost_full_n_out,
  output logic                  read_side_empty_n_out,
  output logic                  almost_empty_n_out,
  output logic                  mailbox_one_flag_n_out,
  output logic                  mailbox_two_flag_n_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // binary to gray
  function automatic logic [PTR_WIDTH-1:0] to_gray(
    input logic [PTR_WIDTH-1:0] bin
  );
    return bin ^ (bin >> 1);
  endfunction

  // gray to binary
  function automatic logic [PTR_WIDTH-1:0] from_gray(
    input logic [PTR_WIDTH-1:0] gray
  );
    logic [PTR_WIDTH-1:0] bin;
    bin[PTR_WIDTH-1] = gray[PTR_WIDTH-1];
    for (int i = PTR_WIDTH - 2; i >= 0; i--)
    begin
      bin[i] = gray[i] ^ bin[i+1];
    end
    return bin;
  endfunction

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [WIDTH-1:0]     mem [WORDS];     // queue storage
  logic [PTR_WIDTH-1:0] wr_ptr;          // write pointer, binary
  logic [PTR_WIDTH-1:0] rd_ptr;          // read pointer, binary
  logic [PTR_WIDTH-1:0] wr_sync1;        // write ptr gray, stage 1
  logic [PTR_WIDTH-1:0] wr_sync2;        // write ptr gray, stage 2
  logic [PTR_WIDTH-1:0] rd_sync1;        // read ptr gray, stage 1
  logic [PTR_WIDTH-1:0] rd_sync2;        // read ptr gray, stage 2
  logic [4:0]           offset;          // almost-flag offset x
  logic [WIDTH-1:0]     out_reg;         // fifo output register
  logic [1:0]           parts_left;      // lanes still unread
  logic [1:0]           cur_width;       // width of word in out_reg
  logic [WIDTH-1:0]     mailbox_one;     // a to b mail
  logic [WIDTH-1:0]     mailbox_two;     // b to a mail

  // next pointers, launched into the synchronisers as gray
  logic [PTR_WIDTH-1:0] next_wr_ptr;
  logic [PTR_WIDTH-1:0] next_rd_ptr;

  // fill levels seen by each side
  logic [PTR_WIDTH-1:0] rd_side_fill;    // words, read side view
  logic [PTR_WIDTH-1:0] wr_side_fill;    // words, write side view

  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  logic a_on;                            // port a selected, strobed
  logic b_on;                            // port b selected, strobed
  logic b_mail;                          // width picks both high
  logic fifo_wr;                         // fifo write this edge
  logic fifo_rd;                         // fifo read this edge
  logic pop;                             // new long word to out_reg
  logic mb1_wr;                          // mailbox one written
  logic mb1_rd;                          // mailbox one read
  logic mb2_wr;                          // mailbox two written
  logic mb2_rd;                          // mailbox two read

  assign a_on   = !port_a_select_n_in && port_a_strobe_on_in;
  assign b_on   = !port_b_select_n_in && port_b_strobe_on_in;
  assign b_mail = port_b_width_sel_hi_in && port_b_width_sel_lo_in;

  // fifo write only while a location is free
  assign fifo_wr = a_on && port_a_dir_select_in
                   && !port_a_mailbox_pick_in
                   && write_side_full_n_out;
  // fifo read only while data waits and a lane width is picked
  assign fifo_rd = b_on && !port_b_dir_select_in
                   && !b_mail
                   && read_side_empty_n_out;
  // a fresh long word leaves memory only when no lanes remain
  assign pop     = fifo_rd && (parts_left == 2'h0);

  // mail writes refused while the box still holds unread mail
  assign mb1_wr = a_on && port_a_dir_select_in
                  && port_a_mailbox_pick_in
                  && mailbox_one_flag_n_out;
  assign mb2_wr = b_on && port_b_dir_select_in && b_mail
                  && mailbox_two_flag_n_out;
  assign mb1_rd = b_on && !port_b_dir_select_in && b_mail;
  assign mb2_rd = a_on && !port_a_dir_select_in
                  && port_a_mailbox_pick_in;

  assign next_wr_ptr = wr_ptr + PTR_WIDTH'(fifo_wr);
  assign next_rd_ptr = rd_ptr + PTR_WIDTH'(pop);

  // fill from own pointer after this edge and the far synced copy,
  // so a side never takes a second access past its own limit
  assign rd_side_fill = from_gray(wr_sync2) - next_rd_ptr;
  assign wr_side_fill = next_wr_ptr - from_gray(rd_sync2);

  // ----------------------------------------------------------------
  // offset register
  // ----------------------------------------------------------------

  // held on the picks while reset stands, frozen from release on
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      unique case ({fill_threshold_pick_hi_in,
                    fill_threshold_pick_lo_in})
        2'b11: offset <= OFFSET_HH;
        2'b10: offset <= OFFSET_HL;
        2'b01: offset <= OFFSET_LH;
        2'b00: offset <= OFFSET_LL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // write side
  // ----------------------------------------------------------------

  // storage write, no reset needed
  always_ff @(posedge sys_clk_in)
  begin
    if (clk_en_in && !reset_in && fifo_wr)
    begin
      mem[wr_ptr[PTR_WIDTH-2:0]] <= port_a_data_in;
    end
  end

  // write pointer
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      wr_ptr <= '0;
    end
    else if (clk_en_in)
    begin
      wr_ptr <= next_wr_ptr;
    end
  end

  // read pointer into the write side: two stages, gray coded;
  // inputs share one clock, so every edge after a read is far
  // enough from it to open the first synchronising cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      rd_sync1 <= '0;
      rd_sync2 <= to_gray(RD_SYNC_RESET);
    end
    else if (clk_en_in)
    begin
      rd_sync1 <= to_gray(next_rd_ptr);
      rd_sync2 <= rd_sync1;
    end
  end

  // full and almost-full flags, registered off stage 2
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      write_side_full_n_out <= 1'b0;
      almost_full_n_out     <= 1'b1;
    end
    else if (clk_en_in)
    begin
      // high again on the second edge after the freeing read
      write_side_full_n_out <=
        (wr_side_fill != PTR_WIDTH'(WORDS));
      // low from 64-x words upward
      almost_full_n_out <=
        (wr_side_fill < PTR_WIDTH'(WORDS) - PTR_WIDTH'(offset));
    end
  end

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------

  // read pointer
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      rd_ptr <= '0;
    end
    else if (clk_en_in)
    begin
      rd_ptr <= next_rd_ptr;
    end
  end

  // write pointer into the read side, two stages, gray coded
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      wr_sync1 <= '0;
      wr_sync2 <= '0;
    end
    else if (clk_en_in)
    begin
      wr_sync1 <= to_gray(next_wr_ptr);
      wr_sync2 <= wr_sync1;
    end
  end

  // output register and lane sequencing for narrow widths
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      out_reg    <= '0;
      parts_left <= 2'h0;
      cur_width  <= WIDTH_LONG;
    end
    else if (clk_en_in && fifo_rd)
    begin
      if (parts_left == 2'h0)
      begin
        // fresh long word; lanes left depend on width picked now
        out_reg   <= mem[rd_ptr[PTR_WIDTH-2:0]];
        cur_width <= {port_b_width_sel_hi_in, port_b_width_sel_lo_in};
        unique case ({port_b_width_sel_hi_in, port_b_width_sel_lo_in})
          WIDTH_BYTE: parts_left <= 2'h3;
          WIDTH_WORD: parts_left <= 2'h1;
          default:    parts_left <= 2'h0;
        endcase
      end
      else
      begin
        // next lane slides down to the low bits
        out_reg <= (cur_width == WIDTH_BYTE) ?
                   (out_reg >> BYTE_BITS) : (out_reg >> WORD_BITS);
        parts_left <= parts_left - 2'h1;
      end
    end
  end

  // empty and almost-empty flags, registered off stage 2
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      read_side_empty_n_out <= 1'b0;
      almost_empty_n_out    <= 1'b0;
    end
    else if (clk_en_in)
    begin
      // stays high while narrow lanes of the last word remain
      read_side_empty_n_out <= (rd_side_fill != '0)
        || (parts_left > 2'h1)
        || ((parts_left == 2'h1) && !fifo_rd)
        || (pop && (port_b_width_sel_hi_in ^ port_b_width_sel_lo_in));
      // high from x+1 stored words, second edge after the write
      almost_empty_n_out <=
        (rd_side_fill > PTR_WIDTH'(offset));
    end
  end

  // ----------------------------------------------------------------
  // mailboxes
  // ----------------------------------------------------------------

  // mail data, kept after reads
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      mailbox_one <= '0;
      mailbox_two <= '0;
    end
    else if (clk_en_in)
    begin
      if (mb1_wr)
      begin
        mailbox_one <= port_a_data_in;
      end
      if (mb2_wr)
      begin
        mailbox_two <= port_b_data_in;
      end
    end
  end

  // mail flags: low on write, high on the far port's read;
  // a write in the same edge as a read wins, no mail is lost
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      mailbox_one_flag_n_out <= 1'b1;
      mailbox_two_flag_n_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      if (mb1_wr)
      begin
        mailbox_one_flag_n_out <= 1'b0;
      end
      else if (mb1_rd)
      begin
        mailbox_one_flag_n_out <= 1'b1;
      end
      if (mb2_wr)
      begin
        mailbox_two_flag_n_out <= 1'b0;
      end
      else if (mb2_rd)
      begin
        mailbox_two_flag_n_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus drivers, registered
  // ----------------------------------------------------------------

  // port a drives mailbox two while selected for reading
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      port_a_data_oe_out <= 1'b0;
      port_a_data_out    <= '0;
    end
    else if (clk_en_in)
    begin
      port_a_data_oe_out <= !port_a_select_n_in
                            && !port_a_dir_select_in;
      port_a_data_out    <= mailbox_two;
    end
  end

  // port b drives the output register or mailbox one
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      port_b_data_oe_out <= 1'b0;
      port_b_data_out    <= '0;
    end
    else if (clk_en_in)
    begin
      port_b_data_oe_out <= !port_b_select_n_in
                            && !port_b_dir_select_in;
      port_b_data_out    <= b_mail ? mailbox_one : out_reg;
    end
  end

endmodule

// ---- test/bus_peer.sv ----
/*
  bus_peer: processor on one data bus of the queue; drives when asked,
  else shows the design's value, else the inverse of the last level.
  assumes: peer and design are not meant to drive at once.
*/
`timescale 1ns/100ps
module bus_peer
(
  // peer side
  input  wire logic        drive_on_in,
  input  wire logic [35:0] drive_val_in,
  // design side
  input  wire logic        dut_oe_in,
  input  wire logic [35:0] dut_val_in,
  // resolved wire
  output logic      [35:0] bus_out
);
  logic [35:0] last = 36'h0;  // last driven level
  // remember what was last driven so a released bus can drift
  always @*
    if (drive_on_in)
      last = drive_val_in;
    else if (dut_oe_in)
      last = dut_val_in;
  assign bus_out = drive_on_in ? drive_val_in :
                   dut_oe_in ? dut_val_in : ~last;
endmodule

// ---- test/fifo_flags_checker.sv ----
/*
  fifo_flags_checker: timing of enables and flags of fifo_port_flags.
  assumes: bound to the design top, one clock, clk_en_in held high.
*/
`timescale 1ns/100ps
module fifo_flags_checker
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // port a control
  input wire logic port_a_select_n_in,
  input wire logic port_a_dir_select_in,
  input wire logic port_a_strobe_on_in,
  input wire logic port_a_mailbox_pick_in,
  // port b control
  input wire logic port_b_select_n_in,
  input wire logic port_b_dir_select_in,
  input wire logic port_b_strobe_on_in,
  input wire logic port_b_width_sel_lo_in,
  input wire logic port_b_width_sel_hi_in,
  // watched outputs
  input wire logic port_a_data_oe_out,
  input wire logic port_b_data_oe_out,
  input wire logic write_side_full_n_out,
  input wire logic read_side_empty_n_out,
  input wire logic almost_empty_n_out,
  input wire logic mailbox_one_flag_n_out,
  input wire logic mailbox_two_flag_n_out
);
  logic [3:0] age;      // edges since reset, saturating
  logic       a_on;     // port a strobed
  logic       b_on;     // port b strobed
  logic       b_mail;   // port b width picks the mailboxes
  logic       rd_take;  // fifo read accepted
  assign a_on = !port_a_select_n_in && port_a_strobe_on_in;
  assign b_on = !port_b_select_n_in && port_b_strobe_on_in;
  assign b_mail = port_b_width_sel_hi_in && port_b_width_sel_lo_in;
  assign rd_take = b_on && !port_b_dir_select_in && !b_mail
                   && read_side_empty_n_out;
  // age counter keeps edge checks clear of reset release
  always_ff @(posedge sys_clk_in)
    if (reset_in)
      age <= 4'h0;
    else if (age != 4'hF)
      age <= age + 4'h1;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in || !clk_en_in);
  a_oe_match_a: assert property (age > 4'h2 |-> port_a_data_oe_out ==
    $past(!port_a_select_n_in && !port_a_dir_select_in))
    else $error("port a enable wrong");
  b_oe_match_a: assert property (age > 4'h2 |-> port_b_data_oe_out ==
    $past(!port_b_select_n_in && !port_b_dir_select_in))
    else $error("port b enable wrong");
  empty_rise_sync_a: assert property (age > 4'h6 &&
    $rose(read_side_empty_n_out) |-> $past(a_on && port_a_dir_select_in
    && !port_a_mailbox_pick_in && write_side_full_n_out, 3))
    else $error("empty flag rose off its write");
  full_rise_sync_a: assert property (age > 4'h6 &&
    $rose(write_side_full_n_out) |-> $past(rd_take, 3))
    else $error("full flag rose off its read");
  empty_fall_read_a: assert property (age > 4'h6 &&
    $fell(read_side_empty_n_out) |-> $past(rd_take) || $past(rd_take, 2))
    else $error("empty flag fell without a read");
  ae_over_ef_a: assert property (almost_empty_n_out |->
    read_side_empty_n_out)
    else $error("almost empty high while empty");
  mail_one_fill_a: assert property (age > 4'h6 &&
    $fell(mailbox_one_flag_n_out) |->
    ##0 ($past(a_on && port_a_dir_select_in && port_a_mailbox_pick_in)
    || $past(a_on && port_a_dir_select_in && port_a_mailbox_pick_in, 2)))
    else $error("mail one flag fell without a write");
  mail_one_free_a: assert property (age > 4'h6 &&
    $rose(mailbox_one_flag_n_out) |-> $past(b_on &&
    !port_b_dir_select_in && b_mail) || $past(b_on &&
    !port_b_dir_select_in && b_mail, 2))
    else $error("mail one flag rose without a read");
  mail_two_fill_a: assert property (age > 4'h6 &&
    $fell(mailbox_two_flag_n_out) |-> $past(b_on &&
    port_b_dir_select_in && b_mail) || $past(b_on &&
    port_b_dir_select_in && b_mail, 2))
    else $error("mail two flag fell without a write");
endmodule
bind fifo_port_flags fifo_flags_checker chk (.sys_clk_in, .reset_in,
  .clk_en_in, .port_a_select_n_in, .port_a_dir_select_in,
  .port_a_strobe_on_in, .port_a_mailbox_pick_in, .port_b_select_n_in,
  .port_b_dir_select_in, .port_b_strobe_on_in, .port_b_width_sel_lo_in,
  .port_b_width_sel_hi_in, .port_a_data_oe_out, .port_b_data_oe_out,
  .write_side_full_n_out, .read_side_empty_n_out, .almost_empty_n_out,
  .mailbox_one_flag_n_out, .mailbox_two_flag_n_out);

// ---- test/tb.sv ----
/*
  tb: self-checking bench for fifo_port_flags: thresholds, full and
  empty limits, all port b widths, both mailboxes.
  assumes: design, checker and bus_peer compiled first.
*/
`timescale 1ns/100ps
`define CHECK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("BAD %s exp %h got %h", nm, exp, got); \
    end \
  end
module tb;
  typedef struct { logic [35:0] val; logic [35:0] mask; } note_t;
  logic        sys_clk, reset, pick_lo, pick_hi;
  logic        a_sel_n, a_dir, a_stb, a_pick, a_drive;
  logic        b_sel_n, b_dir, b_stb, b_lo, b_hi, b_drive;
  logic [35:0] a_val, b_val, a_bus, b_bus, a_dout, b_dout, mail, seen;
  logic        a_oe, b_oe, full_n, af_n, empty_n, ae_n, mb1_n, mb2_n;
  logic [31:0] rnd;
  logic [1:0]  mark, p0 = 2'h0, p1 = 2'h0;  // 1 port b due, 2 port a
  note_t       notes[$], nt;
  logic [35:0] mq[$];                      // words held in the queue
  int          failures = 0, check_count = 0, x;
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  fifo_port_flags DUT (.sys_clk_in(sys_clk), .reset_in(reset),
    .clk_en_in(1'b1), .fill_threshold_pick_lo_in(pick_lo),
    .fill_threshold_pick_hi_in(pick_hi), .port_a_select_n_in(a_sel_n),
    .port_a_dir_select_in(a_dir), .port_a_strobe_on_in(a_stb),
    .port_a_mailbox_pick_in(a_pick), .port_a_data_in(a_bus),
    .port_a_data_out(a_dout), .port_a_data_oe_out(a_oe),
    .port_b_select_n_in(b_sel_n), .port_b_dir_select_in(b_dir),
    .port_b_strobe_on_in(b_stb), .port_b_width_sel_lo_in(b_lo),
    .port_b_width_sel_hi_in(b_hi), .port_b_data_in(b_bus),
    .port_b_data_out(b_dout), .port_b_data_oe_out(b_oe),
    .write_side_full_n_out(full_n), .almost_full_n_out(af_n),
    .read_side_empty_n_out(empty_n), .almost_empty_n_out(ae_n),
    .mailbox_one_flag_n_out(mb1_n), .mailbox_two_flag_n_out(mb2_n));
  bus_peer peer_a (.drive_on_in(a_drive), .drive_val_in(a_val),
    .dut_oe_in(a_oe), .dut_val_in(a_dout), .bus_out(a_bus));
  bus_peer peer_b (.drive_on_in(b_drive), .drive_val_in(b_val),
    .dut_oe_in(b_oe), .dut_val_in(b_dout), .bus_out(b_bus));
  // ------------------------------------------------------------------
  // monitor: a read shows on its port two edges after it is driven
  // ------------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    p0 <= mark;
    p1 <= p0;
  end
  assign seen = p1[1] ? a_dout : b_dout;
  always @(negedge sys_clk)
    if (p1 != 2'h0)
    begin
      nt = notes.pop_front();
      `CHECK("port data", nt.val & nt.mask, seen & nt.mask)
    end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // reset held 16 edges with the offset picks set
  task automatic do_reset(input logic [1:0] code);
    {pick_hi, pick_lo} = code;
    reset = 1'b1;
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    mq.delete();
    `CHECK("reset flags", 6'h27, {full_n, empty_n, ae_n, af_n, mb1_n, mb2_n})
  endtask
  // back to back random writes; keep low marks writes meant to bounce
  task automatic put(input int n, input logic keep);
    for (int i = 0; i < n; i++)
    begin
      rnd = xs(rnd);
      {a_sel_n, a_dir, a_stb, a_pick, a_drive} = 5'b01101;
      a_val = {rnd[3:0], rnd};
      if (keep)
        mq.push_back(a_val);
      @(negedge sys_clk);
    end
    {a_stb, a_drive} = 2'b00;
  endtask
  // back to back reads of n words at width w, lanes low first
  // strobe stays up so reads chain; the caller releases it
  task automatic take(input int n, input logic [1:0] w);
    logic [35:0] word;
    int          lanes;
    lanes = (w == 2'b01) ? 4 : (w == 2'b10) ? 2 : 1;
    for (int i = 0; i < n; i++)
    begin
      word = mq.pop_front();
      for (int j = 0; j < lanes; j++)
      begin
        {b_sel_n, b_dir, b_stb, b_hi, b_lo} = {3'b001, w};
        mark = 2'h1;
        notes.push_back('{word >> (j * 36 / lanes),
                          ~(36'hF_FFFF_FFFF << (36 / lanes))});
        @(negedge sys_clk);
      end
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #100000;
    failures++;
    final_report();
  end
  initial
  begin
    rnd = 32'h6F27;
    {reset, pick_hi, pick_lo, mark} = 5'h10;
    {a_sel_n, a_dir, a_stb, a_pick, a_drive, a_val} = {5'h10, 36'h0};
    {b_sel_n, b_dir, b_stb, b_hi, b_lo, b_drive, b_val} = {6'h20, 36'h0};
    @(negedge sys_clk);
    // every offset pick: almost-empty edge at x and x+1 words
    for (int c = 0; c < 4; c++)
    begin
      do_reset(c[1:0]);
      x = 4 * (c + 1);
      put(x, 1'b1);
      repeat (4) @(negedge sys_clk);
      `CHECK("ae at x", 2'b10, {empty_n, ae_n})
      put(1, 1'b1);
      `CHECK("ae lag", 1'b0, ae_n)
      repeat (3) @(negedge sys_clk);
      `CHECK("ae above x", 1'b1, ae_n)
      take(x + 1, 2'b00);
      {b_stb, mark} = 3'h0;
      repeat (3) @(negedge sys_clk);
      `CHECK("drained", 1'b0, empty_n)
    end
    // fill to the brim, bounce writes, drain in all widths
    do_reset(2'b00);
    put(59, 1'b1);
    repeat (4) @(negedge sys_clk);
    `CHECK("af at 59", 1'b1, af_n)
    put(5, 1'b1);
    repeat (3) @(negedge sys_clk);
    `CHECK("full", 2'b00, {full_n, af_n})
    put(2, 1'b0);
    take(1, 2'b00);
    {b_stb, mark} = 3'h0;
    `CHECK("full lag", 1'b0, full_n)
    repeat (2) @(negedge sys_clk);
    `CHECK("full freed", 1'b1, full_n)
    take(1, 2'b01);
    take(1, 2'b10);
    take(60, 2'b00);
    take(1, 2'b01);
    {b_stb, mark} = 3'h0;
    repeat (2) @(negedge sys_clk);
    `CHECK("empty after lanes", 1'b0, empty_n)
    // mailbox one: write, bounced second write, port b read
    rnd = xs(rnd);
    mail = {rnd[3:0], rnd};
    {a_sel_n, a_dir, a_stb, a_pick, a_drive} = 5'b01111;
    a_val = mail;
    @(negedge sys_clk);
    a_val = ~mail;
    @(negedge sys_clk);
    {a_stb, a_drive} = 2'b00;
    `CHECK("mail one full", 1'b0, mb1_n)
    {b_sel_n, b_dir, b_stb, b_hi, b_lo} = 5'b00111;
    mark = 2'h1;
    notes.push_back('{mail, 36'hF_FFFF_FFFF});
    @(negedge sys_clk);
    {b_stb, mark} = 3'h0;
    repeat (2) @(negedge sys_clk);
    `CHECK("mail one freed", 1'b1, mb1_n)
    // mailbox two: port b peer writes, port a reads
    {b_dir, b_stb, b_drive} = 3'b111;
    b_val = ~mail;
    @(negedge sys_clk);
    {b_stb, b_drive} = 2'b00;
    @(negedge sys_clk);
    `CHECK("mail two full", 1'b0, mb2_n)
    {a_sel_n, a_dir, a_stb, a_pick} = 4'b0011;
    mark = 2'h2;
    notes.push_back('{~mail, 36'hF_FFFF_FFFF});
    @(negedge sys_clk);
    {a_stb, mark} = 3'h0;
    repeat (2) @(negedge sys_clk);
    `CHECK("mail two freed", 1'b1, mb2_n)
    final_report();
  end
endmodule
